/* pkg/rlvc_pkg.sv */
// constants and state type for the regulator low-voltage control block
package rlvc_pkg;
  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [11:0] RLVC_OFF_CTRL = 12'h000;
  localparam logic [11:0] RLVC_OFF_IRQ_STATUS = 12'h004;
  localparam logic [11:0] RLVC_OFF_IRQ_MASK = 12'h008;
  localparam logic [11:0] RLVC_OFF_MODE = 12'h00C;
  // control register field positions
  localparam int RLVC_BIT_CHG_FLAG = 0;
  localparam int RLVC_BIT_IRQ_EN = 1;
  localparam int RLVC_BIT_LV_STATUS = 2;
  // interrupt status field positions
  localparam int RLVC_EV_CHANGE = 0;
  localparam int RLVC_EV_LVRST = 1;
  localparam int RLVC_NUM_EV = 2;
  // reset values
  localparam logic RLVC_RST_IRQ_EN = 1'b0;
  localparam logic RLVC_RST_CHG_FLAG = 1'b0;
  localparam logic [1:0] RLVC_RST_MASK = 2'h0;
  // mode codes as read back in the mode register
  localparam logic [1:0] RLVC_CODE_SHUT = 2'h0;
  localparam logic [1:0] RLVC_CODE_FULL = 2'h1;
  localparam logic [1:0] RLVC_CODE_RED = 2'h2;
  // timing: slave answers one cycle after the setup phase
  localparam int RLVC_PREADY_WAIT = 1;
  // operating modes
  typedef enum logic [1:0] {
    RLVC_SHUTDOWN,
    RLVC_FULL_PERF,
    RLVC_REDUCED_PWR
  } rlvc_mode_t;
endpackage : rlvc_pkg

/* logic/rlvc_sync.sv */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module rlvc_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
  } rlvc_sync_st_t;

  rlvc_sync_st_t st_ff;
  rlvc_sync_st_t nxt_st;

  // -----------------------------------------------------------------------
  // two stages; only the second stage is visible
  // -----------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta_ff = din;
    nxt_st.sync_ff = st_ff.meta_ff;
  end

  // synchronous reset to a constant
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign dout = st_ff.sync_ff;
endmodule : rlvc_sync

/* logic/rlvc_ctrl.sv */
// regulator mode control, reset gating and low-voltage flag logic
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// - full performance outside stop mode, reduced power inside stop mode
// - full performance: detector, low-voltage reset and power-on reset live
// - reduced power: detector and low-voltage reset off, power-on reset kept
// - enable pin low gives shutdown; high gives full or reduced mode
// - shutdown: only power-on reset, outputs released to high impedance
// - status bit 2 is read only; writes ignored
// - status reads 1 only for high detector input in full performance mode
// - enable bit 1 requests interrupt while change flag is set
// - change flag bit 0 sets on every status change, either way
// - change flag clears only on write of one
// - entering reduced power mode never clears change flag; a status drop to 0 sets it
// - power-on reset held until core supply above release level
module rlvc_ctrl
  import rlvc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // core and analog side
  input wire logic STOP_MODE,
  input wire logic REGULATOR_ENABLE_PIN,
  input wire logic LOW_VOLTAGE_DETECTOR,
  input wire logic LV_RESET_CMP,
  input wire logic CORE_SUPPLY_OK,
  // outputs
  output logic POWER_ON_RESET,
  output logic LOW_VOLTAGE_RESET,
  output logic LOW_VOLTAGE_INTERRUPT,
  output logic REG_OUT_ENABLE,
  output logic DETECTOR_ENABLE,
  output logic LV_RESET_ENABLE,
  output logic IRQ
);
  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    rlvc_mode_t mode_ff;
    logic lv_status_ff;
    logic irq_en_ff;
    logic chg_flag_ff;
    logic [RLVC_NUM_EV-1:0] ev_stat_ff;
    logic [RLVC_NUM_EV-1:0] ev_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic por_ff;
    logic lv_rst_ff;
    logic lv_irq_ff;
    logic oen_ff;
    logic det_en_ff;
    logic rst_en_ff;
    logic irq_ff;
  } rlvc_st_t;

  rlvc_st_t st_ff;
  rlvc_st_t nxt_st;

  logic stop_s;
  logic regen_s;
  logic det_s;
  logic rst_cmp_s;
  logic sup_s;

  // -----------------------------------------------------------------------
  // pin inputs come from analog or other domains
  // -----------------------------------------------------------------------
  rlvc_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .din({STOP_MODE, REGULATOR_ENABLE_PIN, LOW_VOLTAGE_DETECTOR,
          LV_RESET_CMP, CORE_SUPPLY_OK}),
    .dout({stop_s, regen_s, det_s, rst_cmp_s, sup_s})
  );

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb
  begin
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic full;
    logic lv_next;
    logic chg_set;
    logic chg_clr;
    logic [RLVC_NUM_EV-1:0] ev_set;
    logic [RLVC_NUM_EV-1:0] ev_clr;
    logic [31:0] rdata;
    setup = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    hit = 1'b0;
    full = 1'b0;
    lv_next = 1'b0;
    chg_set = 1'b0;
    chg_clr = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    rdata = '0;
    nxt_st = st_ff;

    // mode selection; enable pin assumed stable while powered
    if (!regen_s)
      nxt_st.mode_ff = RLVC_SHUTDOWN;
    else if (stop_s)
      nxt_st.mode_ff = RLVC_REDUCED_PWR;
    else
      nxt_st.mode_ff = RLVC_FULL_PERF;
    full = (st_ff.mode_ff == RLVC_FULL_PERF);

    // per-mode feature enables
    case (st_ff.mode_ff)
      RLVC_FULL_PERF:
      begin
        nxt_st.det_en_ff = 1'b1;
        nxt_st.rst_en_ff = 1'b1;
        nxt_st.oen_ff = 1'b1;
      end
      RLVC_REDUCED_PWR:
      begin
        nxt_st.det_en_ff = 1'b0;
        nxt_st.rst_en_ff = 1'b0;
        nxt_st.oen_ff = 1'b1;
      end
      RLVC_SHUTDOWN:
      begin
        nxt_st.det_en_ff = 1'b0;
        nxt_st.rst_en_ff = 1'b0;
        nxt_st.oen_ff = 1'b0; // outputs high impedance
      end
      default:
      begin
        nxt_st.det_en_ff = 1'b0;
        nxt_st.rst_en_ff = 1'b0;
        nxt_st.oen_ff = 1'b0;
      end
    endcase

    // power-on reset live in every mode, held until supply is good
    nxt_st.por_ff = !sup_s;
    // low-voltage reset only in full performance
    nxt_st.lv_rst_ff = full && rst_cmp_s;

    // status follows detector only in full performance
    lv_next = full && det_s;
    nxt_st.lv_status_ff = lv_next;
    // any change sets the flag; mode entry itself never clears it
    chg_set = (lv_next != st_ff.lv_status_ff);

    // apb decode: no wait state, answer in the first access cycle
    setup = PSEL && !PENABLE;
    acc = PSEL && PENABLE;
    // write lands at the edge where the master sees pready high
    wr = acc && PWRITE && st_ff.pready_ff;
    rd = setup && !PWRITE;
    hit = (PADDR == RLVC_OFF_CTRL) || (PADDR == RLVC_OFF_IRQ_STATUS) ||
          (PADDR == RLVC_OFF_IRQ_MASK) || (PADDR == RLVC_OFF_MODE);
    nxt_st.pready_ff = setup;
    nxt_st.pslverr_ff = setup && !hit;

    // register writes; low byte lane holds every field
    if (wr && PSTRB[0])
    begin
      case (PADDR)
        RLVC_OFF_CTRL:
        begin
          // status bit is not writable
          nxt_st.irq_en_ff = PWDATA[RLVC_BIT_IRQ_EN];
          chg_clr = PWDATA[RLVC_BIT_CHG_FLAG]; // write one clears
        end
        RLVC_OFF_IRQ_STATUS:
          ev_clr = PWDATA[RLVC_NUM_EV-1:0];
        RLVC_OFF_IRQ_MASK:
          nxt_st.ev_mask_ff = PWDATA[RLVC_NUM_EV-1:0];
        default:
        begin
        end
      endcase
    end

    // set wins over a clear in the same cycle
    nxt_st.chg_flag_ff = chg_set || (st_ff.chg_flag_ff && !chg_clr);

    // sticky event status for the interrupt controller
    ev_set[RLVC_EV_CHANGE] = chg_set;
    ev_set[RLVC_EV_LVRST] = nxt_st.lv_rst_ff && !st_ff.lv_rst_ff;
    nxt_st.ev_stat_ff = ev_set | (st_ff.ev_stat_ff & ~ev_clr);

    // request level to the core interrupt logic
    nxt_st.lv_irq_ff = nxt_st.chg_flag_ff && nxt_st.irq_en_ff;
    nxt_st.irq_ff = |(nxt_st.ev_stat_ff & nxt_st.ev_mask_ff);

    // read mux captured in setup, shown in access
    if (rd)
    begin
      case (PADDR)
        RLVC_OFF_CTRL:
        begin
          rdata[RLVC_BIT_LV_STATUS] = st_ff.lv_status_ff;
          rdata[RLVC_BIT_IRQ_EN] = st_ff.irq_en_ff;
          rdata[RLVC_BIT_CHG_FLAG] = st_ff.chg_flag_ff;
        end
        RLVC_OFF_IRQ_STATUS:
          rdata[RLVC_NUM_EV-1:0] = st_ff.ev_stat_ff;
        RLVC_OFF_IRQ_MASK:
          rdata[RLVC_NUM_EV-1:0] = st_ff.ev_mask_ff;
        RLVC_OFF_MODE:
        begin
          case (st_ff.mode_ff)
            RLVC_FULL_PERF: rdata[1:0] = RLVC_CODE_FULL;
            RLVC_REDUCED_PWR: rdata[1:0] = RLVC_CODE_RED;
            default: rdata[1:0] = RLVC_CODE_SHUT;
          endcase
        end
        default:
          rdata = '0;
      endcase
      nxt_st.prdata_ff = rdata;
    end
    else
      nxt_st.prdata_ff = '0; // read data stands only in the access cycle
  end

  // -----------------------------------------------------------------------
  // registers; reset holds power-on reset asserted
  // -----------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_ff <= '0;
      st_ff.mode_ff <= RLVC_SHUTDOWN;
      st_ff.irq_en_ff <= RLVC_RST_IRQ_EN;
      st_ff.chg_flag_ff <= RLVC_RST_CHG_FLAG;
      st_ff.ev_mask_ff <= RLVC_RST_MASK;
      st_ff.por_ff <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // -----------------------------------------------------------------------
  // outputs straight from flops
  // -----------------------------------------------------------------------
  assign PRDATA = st_ff.prdata_ff;
  assign PREADY = st_ff.pready_ff;
  assign PSLVERR = st_ff.pslverr_ff;
  assign POWER_ON_RESET = st_ff.por_ff;
  assign LOW_VOLTAGE_RESET = st_ff.lv_rst_ff;
  assign LOW_VOLTAGE_INTERRUPT = st_ff.lv_irq_ff;
  assign REG_OUT_ENABLE = st_ff.oen_ff;
  assign DETECTOR_ENABLE = st_ff.det_en_ff;
  assign LV_RESET_ENABLE = st_ff.rst_en_ff;
  assign IRQ = st_ff.irq_ff;
endmodule : rlvc_ctrl

/* testbench/rlvc_far_model.sv */
// far-side model: stop control, supply monitor and comparators
`timescale 1ns/1ns
module rlvc_far_model
(
  input wire logic CLK,
  input wire logic [4:0] want,
  output logic STOP_MODE,
  output logic REGULATOR_ENABLE_PIN,
  output logic LOW_VOLTAGE_DETECTOR,
  output logic LV_RESET_CMP,
  output logic CORE_SUPPLY_OK
);
  // ---------------------------------------------------------------
  // pin drive, want = {stop, enable, detector, lv reset, supply ok}
  // ---------------------------------------------------------------
  initial
  begin
    {STOP_MODE, LOW_VOLTAGE_DETECTOR, LV_RESET_CMP} = 3'h0;
    {REGULATOR_ENABLE_PIN, CORE_SUPPLY_OK} = 2'h3;
  end
  // enable pin moves only while the core is unpowered
  always @(posedge CLK)
  begin
    STOP_MODE <= want[4];
    LOW_VOLTAGE_DETECTOR <= want[2];
    LV_RESET_CMP <= want[1];
    CORE_SUPPLY_OK <= want[0];
    if (!want[0] && !CORE_SUPPLY_OK)
      REGULATOR_ENABLE_PIN <= want[3];
  end
endmodule : rlvc_far_model

/* testbench/rlvc_ctrl_monitor.sv */
// port assertions for the regulator control block
`timescale 1ns/1ns
module rlvc_ctrl_monitor
  import rlvc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic STOP_MODE,
  input wire logic REGULATOR_ENABLE_PIN,
  input wire logic CORE_SUPPLY_OK,
  input wire logic POWER_ON_RESET,
  input wire logic LOW_VOLTAGE_RESET,
  input wire logic LOW_VOLTAGE_INTERRUPT,
  input wire logic REG_OUT_ENABLE,
  input wire logic DETECTOR_ENABLE,
  input wire logic LV_RESET_ENABLE
);
  // ---------------------------------------------------------------
  // checks; pins pass sync flops, so steady runs of four to six are used
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic acc;
  assign acc = PSEL && PENABLE && PREADY && PADDR == RLVC_OFF_CTRL;
  a_lv_pair: assert property (DETECTOR_ENABLE == LV_RESET_ENABLE)
    else $error("detector and reset enables differ");
  a_shut_off: assert property (!REG_OUT_ENABLE |-> !DETECTOR_ENABLE)
    else $error("detector live in shutdown");
  a_lv_rst_gate: assert property (LOW_VOLTAGE_RESET
    |-> LV_RESET_ENABLE)
    else $error("low-voltage reset outside full mode");
  a_stop_red: assert property (STOP_MODE [*6]
    |=> !DETECTOR_ENABLE)
    else $error("detector live in stop");
  a_full_run: assert property ((!STOP_MODE
    && REGULATOR_ENABLE_PIN) [*6] |=> DETECTOR_ENABLE)
    else $error("full mode not entered");
  a_shut_pin: assert property (!REGULATOR_ENABLE_PIN [*6]
    |=> !REG_OUT_ENABLE)
    else $error("outputs driven with enable low");
  a_por_hold: assert property (!CORE_SUPPLY_OK [*4] |=> POWER_ON_RESET)
    else $error("power-on reset released early");
  a_por_free: assert property (CORE_SUPPLY_OK [*5] |=> !POWER_ON_RESET)
    else $error("power-on reset stuck");
  a_irq_off: assert property (acc && PWRITE && PSTRB[0]
    && !PWDATA[1] |-> ##[1:2] !LOW_VOLTAGE_INTERRUPT)
    else $error("interrupt with enable cleared");
  a_rd_stat: assert property (acc && !PWRITE
    && !DETECTOR_ENABLE && !$past(DETECTOR_ENABLE)
    |-> !PRDATA[RLVC_BIT_LV_STATUS])
    else $error("status set outside full mode");
  c_write: cover property (acc && PWRITE);
  c_irq: cover property ($rose(LOW_VOLTAGE_INTERRUPT));
  c_shut: cover property ($fell(REG_OUT_ENABLE));
endmodule : rlvc_ctrl_monitor
bind rlvc_ctrl rlvc_ctrl_monitor u_mon (.CLK, .RST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .STOP_MODE,
  .REGULATOR_ENABLE_PIN, .CORE_SUPPLY_OK, .POWER_ON_RESET,
  .LOW_VOLTAGE_RESET, .LOW_VOLTAGE_INTERRUPT, .REG_OUT_ENABLE,
  .DETECTOR_ENABLE, .LV_RESET_ENABLE);

/* testbench/regulator_low_voltage_control_tb_top.sv */
// self-checking bench for the regulator low-voltage control block
`timescale 1ns/1ns
module regulator_low_voltage_control_tb_top;
  import rlvc_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'hF;
  logic PREADY, PSLVERR, STOP_MODE, REGULATOR_ENABLE_PIN;
  logic LOW_VOLTAGE_DETECTOR, LV_RESET_CMP, CORE_SUPPLY_OK, POWER_ON_RESET;
  logic LOW_VOLTAGE_RESET, LOW_VOLTAGE_INTERRUPT, REG_OUT_ENABLE;
  logic DETECTOR_ENABLE, LV_RESET_ENABLE, IRQ;
  logic [4:0] want = 5'h09;
  logic [32:0] exp_q[$];
  logic [15:0] lfsr = 16'h3B86;
  int errors = 0, n_checks = 0;
  rlvc_ctrl dut (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB, .PRDATA, .PREADY, .PSLVERR, .STOP_MODE, .REGULATOR_ENABLE_PIN,
    .LOW_VOLTAGE_DETECTOR, .LV_RESET_CMP, .CORE_SUPPLY_OK, .POWER_ON_RESET,
    .LOW_VOLTAGE_RESET, .LOW_VOLTAGE_INTERRUPT, .REG_OUT_ENABLE,
    .DETECTOR_ENABLE, .LV_RESET_ENABLE, .IRQ);
  rlvc_far_model far (.CLK, .want, .STOP_MODE, .REGULATOR_ENABLE_PIN,
    .LOW_VOLTAGE_DETECTOR, .LV_RESET_CMP, .CORE_SUPPLY_OK);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial
    forever #25 CLK = ~CLK;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // random source: 16-bit maximal-length shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic pause(input int n);
    repeat (n) @(posedge CLK);
  endtask : pause
  // far-side pins move, then the sync chain gets time to settle
  task automatic far_set(input logic [4:0] v);
    want <= v;
    pause(8);
  endtask : far_set
  // one apb transfer; a read leaves its expected answer as a note
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    if (!w)
      exp_q.push_back(e);
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    {PSEL, PENABLE} <= 2'b00;
    if (n == 20)
    begin
      errors++;
      stop_test();
    end
  endtask : apb
  // scoreboard: each read answer against the oldest note
  always @(posedge CLK)
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1)
      chk({PSLVERR, PRDATA}, exp_q.pop_front());
  // watchdog against a hung run
  initial
  begin
    pause(20000);
    errors++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // scenarios; want = {stop, enable, detector, lv reset, supply ok}
  // ---------------------------------------------------------------
  initial
  begin
    pause(12);
    RST_N <= 1'b1;
    pause(8);
    apb(0, RLVC_OFF_CTRL, 0, 33'h0);
    apb(0, RLVC_OFF_MODE, 0, {31'h0, RLVC_CODE_FULL});
    apb(0, RLVC_OFF_IRQ_MASK, 0, {31'h0, RLVC_RST_MASK});
    chk(DETECTOR_ENABLE & LV_RESET_ENABLE & REG_OUT_ENABLE, 1'b1);
    chk(POWER_ON_RESET, 1'b0);
    $display("test start done");
    far_set(5'h0D);
    apb(0, RLVC_OFF_CTRL, 0, 33'h5);
    chk(LOW_VOLTAGE_INTERRUPT, 1'b0);
    apb(1, RLVC_OFF_CTRL, 32'h2, 0);
    apb(0, RLVC_OFF_CTRL, 0, 33'h7);
    chk(LOW_VOLTAGE_INTERRUPT, 1'b1);
    apb(1, RLVC_OFF_IRQ_MASK, 32'h1, 0);
    pause(2);
    chk(IRQ, 1'b1);
    apb(1, RLVC_OFF_IRQ_STATUS, 32'h3, 0);
    pause(2);
    chk(IRQ, 1'b0);
    apb(1, RLVC_OFF_CTRL, 32'h3, 0);
    apb(0, RLVC_OFF_CTRL, 0, 33'h6);
    chk(LOW_VOLTAGE_INTERRUPT, 1'b0);
    $display("test flag done");
    far_set(5'h09);
    far_set(5'h19);
    apb(0, RLVC_OFF_CTRL, 0, 33'h3);
    apb(0, RLVC_OFF_MODE, 0, {31'h0, RLVC_CODE_RED});
    chk(DETECTOR_ENABLE | LV_RESET_ENABLE | POWER_ON_RESET, 1'b0);
    far_set(5'h1F);
    chk(LOW_VOLTAGE_RESET, 1'b0);
    apb(1, RLVC_OFF_CTRL, 32'h7, 0);
    apb(0, RLVC_OFF_CTRL, 0, 33'h2);
    far_set(5'h0F);
    chk(LOW_VOLTAGE_RESET, 1'b1);
    // enable off, then a write with lane 0 disabled must be ignored
    apb(1, RLVC_OFF_CTRL, 32'h0, 0);
    PSTRB <= 4'hE;
    apb(1, RLVC_OFF_CTRL, 32'h3, 0);
    PSTRB <= 4'hF;
    apb(0, RLVC_OFF_CTRL, 0, 33'h5);
    chk(LOW_VOLTAGE_INTERRUPT, 1'b0);
    $display("test stop done");
    far_set(5'h08);
    chk(POWER_ON_RESET, 1'b1);
    far_set(5'h00);
    chk(REG_OUT_ENABLE | DETECTOR_ENABLE, 1'b0);
    chk(POWER_ON_RESET, 1'b1);
    apb(0, RLVC_OFF_MODE, 0, {31'h0, RLVC_CODE_SHUT});
    far_set(5'h08);
    far_set(5'h09);
    chk(REG_OUT_ENABLE & ~POWER_ON_RESET, 1'b1);
    $display("test shutdown done");
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      apb(1, RLVC_OFF_IRQ_MASK, {16'h0, lfsr}, 0);
      apb(0, RLVC_OFF_IRQ_MASK, 0, {31'h0, lfsr[1:0]});
    end
    apb(1, 12'h010, 32'hF, 0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    $display("test map done");
    stop_test();
  end
endmodule : regulator_low_voltage_control_tb_top
